// >>> src/pmc_top.sv
// Functional notes
// R1: Writing the source select never changes the running clock by itself.
// R2: Mode entry stops clocks, counts eight new-source edges, then resumes. The code does so only when the source changes.
// R3: Three flags show primary, stable internal or secondary as system clock.
// R4: All flags clear means slow internal clock or fast one not yet stable.
// R5: Internal-as-primary lets primary and internal flags both be set.
// R6: Each mode entry uses the gate and select bits current at that moment.
// R7: Watchdog expiry wakes from idle or sleep; in run modes it resets. The code resets only in PMC_ST_PM and ignores it in PMC_ST_RUN.
// R8: A mode entry that changes the source performs a clock switch.
// R9: Idle wake runs on the current source, then switches to primary when ready.
// R10: Wake-up sequences never modify the gate bit or source select.
// R11: Gate and select all zero make a mode entry enter sleep; reset value.
// R12: Sleep entry shuts the primary oscillator and clears the primary flag.
// R13: Sleep wake holds clocks until primary ready, unless two-speed start.
// R14: Gate bit stops the CPU clock; peripherals keep the selected source.
// R15: Idle exits only by interrupt, watchdog time-out or reset.
// R16: After an idle wake the CPU waits about ten microseconds.
// R17: Primary idle keeps primary clock and flag; CPU wakes on primary.
// R18: Secondary idle switches to secondary, stops primary, updates flags.
// R19: Secondary selected while its enable is clear: mode entry ignored.
// R20: Secondary enabled but not oscillating: clocks wait for its edges.
// R21: Secondary idle wake runs on secondary, then returns to primary.
// R22: Upper select bit chooses internal; 01 secondary; 00 primary.
// R23: Flags change only once the clock switch has completed.
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defs.svh"

module pmc_top (
    input  wire logic                 aclk, // System clock, 100 MHz.
    input  wire logic                 aresetn, // Synchronous reset, active low.
    input  wire logic [7:0]           s_axi_awaddr, // Write address.
    input  wire logic                 s_axi_awvalid, // Write address valid.
    output logic                      s_axi_awready, // Write address ready.
    input  wire logic [31:0]          s_axi_wdata, // Write data.
    input  wire logic [3:0]           s_axi_wstrb, // Write byte strobes.
    input  wire logic                 s_axi_wvalid, // Write data valid.
    output logic                      s_axi_wready, // Write data ready.
    output logic [1:0]                s_axi_bresp, // Write response.
    output logic                      s_axi_bvalid, // Write response valid.
    input  wire logic                 s_axi_bready, // Write response ready.
    input  wire logic [7:0]           s_axi_araddr, // Read address.
    input  wire logic                 s_axi_arvalid, // Read address valid.
    output logic                      s_axi_arready, // Read address ready.
    output logic [31:0]               s_axi_rdata, // Read data.
    output logic [1:0]                s_axi_rresp, // Read response.
    output logic                      s_axi_rvalid, // Read data valid.
    input  wire logic                 s_axi_rready, // Read data ready.
    input  wire logic                 mode_entry, // Mode-entry instruction pulse.
    input  wire logic                 irq_wake, // Interrupt wake request.
    input  wire logic                 wdt_expire, // Watchdog time-out pulse.
    input  wire pmc_pkg::pmc_osc_in_t osc_in, // Oscillator status and edges.
    output pmc_pkg::pmc_clk_out_t     clk_out, // Clock gating and select.
    output logic                      wdt_reset // Watchdog reset pulse.
);
    import pmc_pkg::*;

    // Whole module state in one record.
    typedef struct packed {
        pmc_state_t   state;
        pmc_src_t     tgt_src;
        logic         tgt_gate;
        logic [9:0]   cnt;
        pmc_clk_out_t clk;
        pmc_flags_t   flags;
        logic         wdt_rst;
        logic         gate_r;
        logic [1:0]   sel_r;
        logic         sec_en_r;
        logic         int_pri_r;
        logic         two_speed_r;
        logic [2:0]   freq_r;
        logic         aw_held;
        logic [7:0]   aw_addr;
        logic         w_held;
        logic [31:0]  w_data;
        logic [3:0]   w_strb;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         rvalid;
        logic [31:0]  rdata;
        logic [1:0]   rresp;
    } pmc_regs_t;

    pmc_regs_t s_reg;
    pmc_regs_t s_next;

    // Source from the select field;
    // the upper bit overrides the lower.
    function automatic pmc_src_t sel_to_src(input logic [1:0] sel);
        if (sel[1]) begin  // [R22]
            sel_to_src = PMC_SRC_INT;
        end else if (sel[0]) begin
            sel_to_src = PMC_SRC_SEC;
        end else begin
            sel_to_src = PMC_SRC_PRI;
        end
    endfunction : sel_to_src

    // Edge of a source; a stopped secondary gives none,
    // so the clocks stay off until it starts.
    function automatic logic src_tick(input pmc_src_t src, input pmc_osc_in_t o);
        case (src)
            PMC_SRC_PRI: src_tick = o.pri_tick;
            PMC_SRC_SEC: src_tick = o.sec_tick & o.sec_running;  // [R20]
            PMC_SRC_INT: src_tick = o.int_tick;
            default:     src_tick = 1'b0;
        endcase
    endfunction : src_tick

    // Flags as a function of the source actually driving the system.
    function automatic pmc_flags_t flags_for(input pmc_src_t src,
        input pmc_regs_t r,
        input logic int_stable);
        logic int_on;
        int_on = int_stable & (r.freq_r != `PMC_FREQ_RST);  // [R4]
        flags_for.pri  = (src == PMC_SRC_PRI);  // [R3]
        flags_for.sec  = (src == PMC_SRC_SEC);  // [R3]
        flags_for.intl = int_on & ((src == PMC_SRC_INT) |
                         ((src == PMC_SRC_PRI) & r.int_pri_r));  // [R5]
    endfunction : flags_for

    // Register read mux; unmapped addresses flag a slave error.
    function automatic logic [32:0] reg_read(input logic [7:0] addr, input pmc_regs_t r);
        reg_read = 33'h0_0000_0000;
        case (addr)
            `PMC_OSC_CTRL_OFS: begin
                reg_read[`PMC_GATE_BIT] = r.gate_r;
                reg_read[`PMC_PRI_FLAG_BIT] = r.flags.pri;
                reg_read[`PMC_INT_FLAG_BIT] = r.flags.intl;
                reg_read[`PMC_SEL_MSB:`PMC_SEL_LSB] = r.sel_r;
            end
            `PMC_SEC_CTRL_OFS: begin
                reg_read[`PMC_SEC_FLAG_BIT] = r.flags.sec;
                reg_read[`PMC_SEC_EN_BIT] = r.sec_en_r;
            end
            `PMC_CFG_OFS: begin
                reg_read[`PMC_INT_PRI_BIT] = r.int_pri_r;
                reg_read[`PMC_TWO_SPEED_BIT] = r.two_speed_r;
                reg_read[`PMC_FREQ_MSB:`PMC_FREQ_LSB] = r.freq_r;
            end
            `PMC_STATUS_OFS: begin
                reg_read[7:0] = {r.clk.cpu_clk_en, r.clk.periph_clk_en,
                                 r.clk.primary_osc_en, r.clk.clk_sel, r.state};
            end
            default: reg_read[32] = 1'b1;
        endcase
    endfunction : reg_read

    // Next state: bus slave, registers and sequencer.
    always_comb begin
        pmc_src_t   tgt;
        logic       do_write;
        logic       wake;
        logic [32:0] rd;
        s_next   = s_reg;
        tgt      = sel_to_src(s_reg.sel_r);
        wake     = irq_wake | wdt_expire;
        rd       = reg_read(s_axi_araddr, s_reg);
        do_write = s_reg.aw_held & s_reg.w_held & ~s_reg.bvalid;
        s_next.wdt_rst = 1'b0;

        // Address and data are taken in either order.
        if (s_axi_awvalid && s_axi_awready) begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_next.w_held = 1'b1;
            s_next.w_data = s_axi_wdata;
            s_next.w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            s_next.aw_held = 1'b0;
            s_next.w_held  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = `PMC_RESP_OKAY;
            // Stored only; the sequencer samples these at mode entry.
            if (s_reg.w_strb[0]) begin  // [R1]
                case (s_reg.aw_addr)
                    `PMC_OSC_CTRL_OFS: begin
                        s_next.gate_r = s_reg.w_data[`PMC_GATE_BIT];
                        s_next.sel_r  = s_reg.w_data[`PMC_SEL_MSB:`PMC_SEL_LSB];
                    end
                    `PMC_SEC_CTRL_OFS: s_next.sec_en_r = s_reg.w_data[`PMC_SEC_EN_BIT];
                    `PMC_CFG_OFS: begin
                        s_next.int_pri_r   = s_reg.w_data[`PMC_INT_PRI_BIT];
                        s_next.two_speed_r = s_reg.w_data[`PMC_TWO_SPEED_BIT];
                        s_next.freq_r      = s_reg.w_data[`PMC_FREQ_MSB:`PMC_FREQ_LSB];
                    end
                    default: s_next.bresp = `PMC_RESP_SLVERR;
                endcase
            end else if (s_reg.aw_addr > `PMC_STATUS_OFS || s_reg.aw_addr[1:0] != 2'h0) begin
                s_next.bresp = `PMC_RESP_SLVERR;
            end
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            s_next.rvalid = 1'b1;
            s_next.rdata  = rd[31:0];
            s_next.rresp  = rd[32] ? `PMC_RESP_SLVERR : `PMC_RESP_OKAY;
        end else if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end

        // Mode sequencer.
        case (s_reg.state)
            PMC_ST_RUN, PMC_ST_PM: begin
                if (s_reg.state == PMC_ST_PM && s_reg.tgt_gate) begin
                    // CPU is halted, so only wake events leave idle.
                    if (wake) begin  // [R15] [R7]
                        s_next.state = PMC_ST_WAKE;
                        s_next.cnt = 10'h000;
                        s_next.clk.primary_osc_en = 1'b1;
                    end
                end else if (s_reg.state == PMC_ST_PM && wdt_expire) begin
                    s_next.wdt_rst = 1'b1;  // [R7]
                end else if (mode_entry) begin
                    // Bits sampled as they stand now, every time.
                    if (!s_reg.gate_r && s_reg.sel_r == `PMC_SEL_RST) begin  // [R6] [R11]
                        s_next.state = PMC_ST_SLEEP;
                        s_next.clk.clk_sel = PMC_SRC_NONE;
                        s_next.clk.cpu_clk_en = 1'b0;
                        s_next.clk.periph_clk_en = 1'b0;
                        s_next.clk.primary_osc_en = 1'b0;  // [R12]
                    end else if (tgt == PMC_SRC_SEC && !s_reg.sec_en_r) begin
                        s_next.state = s_reg.state;  // [R19]
                    end else begin
                        s_next.tgt_src  = tgt;
                        s_next.tgt_gate = s_reg.gate_r;
                        if (tgt == s_reg.clk.clk_sel) begin
                            // Same source: only the CPU gate changes.
                            s_next.state          = PMC_ST_PM;
                            s_next.clk.cpu_clk_en = ~s_reg.gate_r;  // [R14] [R17]
                        end else begin
                            s_next.state = PMC_ST_SWITCH;  // [R8]
                            s_next.cnt = 10'h000;
                            s_next.clk.cpu_clk_en = 1'b0;  // [R2]
                            s_next.clk.periph_clk_en = 1'b0;
                        end
                    end
                end else if (s_reg.state == PMC_ST_PM && irq_wake) begin
                    // Run mode woken: back to the primary.
                    s_next.state = PMC_ST_WAITPRI;
                    s_next.clk.primary_osc_en = 1'b1;
                end
            end
            PMC_ST_SWITCH: begin
                if (src_tick(s_reg.tgt_src, osc_in)) begin
                    if (s_reg.cnt == `PMC_SYNC_EDGES - 10'h001) begin  // [R2]
                        s_next.state = PMC_ST_PM;
                        s_next.clk.clk_sel = s_reg.tgt_src;  // [R18]
                        s_next.clk.periph_clk_en = 1'b1;  // [R14]
                        s_next.clk.cpu_clk_en = ~s_reg.tgt_gate;
                        s_next.clk.primary_osc_en = (s_reg.tgt_src == PMC_SRC_PRI);
                    end else begin
                        s_next.cnt = s_reg.cnt + 10'h001;
                    end
                end
            end
            PMC_ST_WAKE: begin
                // CPU start waits while peripherals keep running.
                if (s_reg.cnt == 10'(`PMC_WAKE_CYC - 1)) begin  // [R16]
                    s_next.clk.cpu_clk_en = 1'b1;
                    s_next.tgt_gate       = 1'b0;
                    // Primary idle wakes straight into primary run.
                    s_next.state = (s_reg.clk.clk_sel == PMC_SRC_PRI) ?
                                   PMC_ST_RUN : PMC_ST_WAITPRI;  // [R17] [R9] [R21]
                end else begin
                    s_next.cnt = s_reg.cnt + 10'h001;
                end
            end
            PMC_ST_WAITPRI: begin
                if (osc_in.pri_ready) begin
                    if (s_reg.clk.clk_sel == PMC_SRC_NONE) begin
                        // Clocks held off during the wait; start on primary.
                        s_next.state = PMC_ST_RUN;  // [R13]
                        s_next.clk.clk_sel = PMC_SRC_PRI;
                        s_next.clk.periph_clk_en = 1'b1;
                        s_next.clk.cpu_clk_en = 1'b1;
                    end else begin
                        s_next.state = PMC_ST_BACK;  // [R9]
                        s_next.cnt = 10'h000;
                        s_next.clk.periph_clk_en = 1'b0;
                        s_next.clk.cpu_clk_en = 1'b0;
                    end
                end
            end
            PMC_ST_BACK: begin
                if (osc_in.pri_tick) begin
                    if (s_reg.cnt == `PMC_SYNC_EDGES - 10'h001) begin  // [R2]
                        // The secondary is left running.
                        s_next.state = PMC_ST_RUN;  // [R21]
                        s_next.clk.clk_sel = PMC_SRC_PRI;
                        s_next.clk.periph_clk_en = 1'b1;
                        s_next.clk.cpu_clk_en = 1'b1;
                    end else begin
                        s_next.cnt = s_reg.cnt + 10'h001;
                    end
                end
            end
            PMC_ST_SLEEP: begin
                if (wake) begin  // [R7]
                    s_next.state = PMC_ST_WAITPRI;
                    s_next.clk.primary_osc_en = 1'b1;
                    if (s_reg.two_speed_r) begin
                        // Run from the internal block while the primary starts.
                        s_next.clk.clk_sel = PMC_SRC_INT;  // [R13]
                        s_next.clk.periph_clk_en = 1'b1;
                        s_next.clk.cpu_clk_en = 1'b1;
                    end
                end
            end
            default: s_next.state = PMC_ST_RUN;
        endcase

        // Flags hold during a switch, so they never
        // claim a source not yet clocking.
        if (s_next.state != PMC_ST_SWITCH && s_next.state != PMC_ST_BACK) begin  // [R23]
            s_next.flags = flags_for(s_next.clk.clk_sel, s_reg, osc_in.int_stable);
        end
    end

    // State register; only the bus touches gate and select.
    always_ff @(posedge aclk) begin  // [R10]
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.state <= PMC_ST_RUN;
            s_reg.clk.clk_sel <= PMC_SRC_PRI;
            s_reg.clk.cpu_clk_en <= 1'b1;
            s_reg.clk.periph_clk_en <= 1'b1;
            s_reg.clk.primary_osc_en <= 1'b1;
            s_reg.flags.pri <= 1'b1;
            s_reg.sel_r <= `PMC_SEL_RST;  // [R11]
            s_reg.freq_r <= `PMC_FREQ_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // Bus handshakes: one outstanding write and one read at a time.
    assign s_axi_awready = ~s_reg.aw_held & ~s_reg.bvalid;
    assign s_axi_wready  = ~s_reg.w_held & ~s_reg.bvalid;
    assign s_axi_bvalid  = s_reg.bvalid;
    assign s_axi_bresp   = s_reg.bresp;
    assign s_axi_arready = ~s_reg.rvalid;
    assign s_axi_rvalid  = s_reg.rvalid;
    assign s_axi_rdata   = s_reg.rdata;
    assign s_axi_rresp   = s_reg.rresp;

    // Clock controls straight from flops.
    assign clk_out   = s_reg.clk;
    assign wdt_reset = s_reg.wdt_rst;

endmodule : pmc_top
`default_nettype wire

// >>> src/pmc_defs.svh
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// Register byte offsets.
`define PMC_OSC_CTRL_OFS   8'h00
`define PMC_SEC_CTRL_OFS   8'h04
`define PMC_CFG_OFS        8'h08
`define PMC_STATUS_OFS     8'h0C

// Oscillator control register fields.
`define PMC_GATE_BIT       7
`define PMC_PRI_FLAG_BIT   3
`define PMC_INT_FLAG_BIT   2
`define PMC_SEL_MSB        1
`define PMC_SEL_LSB        0

// Secondary control fields.
`define PMC_SEC_FLAG_BIT   6
`define PMC_SEC_EN_BIT     3

// Configuration register fields.
`define PMC_INT_PRI_BIT    0
`define PMC_TWO_SPEED_BIT  1
`define PMC_FREQ_MSB       6
`define PMC_FREQ_LSB       4

// Reset values of the writable fields.
`define PMC_SEL_RST        2'h0
`define PMC_FREQ_RST       3'h0

// Eight edges of the new source.
`define PMC_SYNC_EDGES     10'h008

// Wake delay and clock rate.
`define PMC_WAKE_DLY_US    10
`define PMC_CLK_MHZ        100
`define PMC_WAKE_CYC       (`PMC_WAKE_DLY_US * `PMC_CLK_MHZ)

// AXI responses.
`define PMC_RESP_OKAY      2'h0
`define PMC_RESP_SLVERR    2'h2

`endif

// >>> src/pmc_pkg.sv
package pmc_pkg;

    // Sequencer states, Gray coded along the usual path.
    typedef enum logic [2:0] {
        PMC_ST_RUN     = 3'h0,
        PMC_ST_SWITCH  = 3'h1,
        PMC_ST_PM      = 3'h3,
        PMC_ST_WAKE    = 3'h2,
        PMC_ST_WAITPRI = 3'h6,
        PMC_ST_BACK    = 3'h7,
        PMC_ST_SLEEP   = 3'h5
    } pmc_state_t;

    // System clock source.
    typedef enum logic [1:0] {
        PMC_SRC_PRI  = 2'h0,
        PMC_SRC_SEC  = 2'h1,
        PMC_SRC_INT  = 2'h2,
        PMC_SRC_NONE = 2'h3
    } pmc_src_t;

    // Oscillator-side inputs; ticks are one-cycle pulses per source edge.
    typedef struct packed {
        logic pri_ready;
        logic pri_tick;
        logic sec_running;
        logic sec_tick;
        logic int_stable;
        logic int_tick;
    } pmc_osc_in_t;

    // Clock control outputs.
    typedef struct packed {
        logic     cpu_clk_en;
        logic     periph_clk_en;
        pmc_src_t clk_sel;
        logic     primary_osc_en;
    } pmc_clk_out_t;

    // Clock-status flags.
    typedef struct packed {
        logic pri;
        logic intl;
        logic sec;
    } pmc_flags_t;

endpackage : pmc_pkg

// >>> dv/pmc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pmc_top_asserts (
    input wire logic                  aclk, // Clock.
    input wire logic                  aresetn, // Reset, active low.
    input wire logic                  s_axi_awvalid, // Bus.
    input wire logic                  s_axi_awready, // Bus.
    input wire logic                  s_axi_wvalid, // Bus.
    input wire logic                  s_axi_wready, // Bus.
    input wire logic                  s_axi_bvalid, // Bus.
    input wire logic                  s_axi_arvalid, // Bus.
    input wire logic                  s_axi_arready, // Bus.
    input wire logic [31:0]           s_axi_rdata, // Bus.
    input wire logic                  s_axi_rvalid, // Bus.
    input wire logic                  s_axi_rready, // Bus.
    input wire logic                  irq_wake, // Wake request.
    input wire logic                  wdt_expire, // Watchdog pulse.
    input wire pmc_pkg::pmc_clk_out_t clk_out, // Clock controls.
    input wire logic                  wdt_reset // Watchdog reset.
);
    import pmc_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Bus answers: fixed latency, held until taken.
    chk_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("late read");
    chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    chk_wr_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("bad write latency");
    // A source change follows a clock pause.
    chk_sel_paused: assert property ($changed(clk_out.clk_sel)
        && clk_out.clk_sel != PMC_SRC_NONE |-> !$past(clk_out.periph_clk_en))
        else $error("switch without pause");
    chk_pri_osc_on: assert property (clk_out.clk_sel == PMC_SRC_PRI
        && clk_out.periph_clk_en |-> clk_out.primary_osc_en) else $error("primary used while off");
    chk_sleep_off: assert property (clk_out.clk_sel == PMC_SRC_NONE
        |-> !clk_out.periph_clk_en && !clk_out.cpu_clk_en) else $error("clocks on without source");
    chk_cpu_gate: assert property (clk_out.cpu_clk_en |-> clk_out.periph_clk_en)
        else $error("cpu on, peripherals off");
    chk_wake_delay: assert property (irq_wake && !clk_out.cpu_clk_en
        && clk_out.periph_clk_en |=> !clk_out.cpu_clk_en [*8]) else $error("cpu woke too soon");
    chk_wdt_cause: assert property (wdt_reset
        |-> $past(wdt_expire) && $past(clk_out.cpu_clk_en)) else $error("stray watchdog reset");
endmodule : pmc_top_asserts
`default_nettype wire

// >>> dv/pmc_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmc_osc_model (
    input  wire logic                  aclk,    // Clock.
    input  wire logic                  aresetn, // Reset, active low.
    input  wire pmc_pkg::pmc_clk_out_t clk_out, // Controls from the block.
    output wire pmc_pkg::pmc_osc_in_t  osc_in   // Oscillator status and edges.
);
    import pmc_pkg::*;
    int warm = 20; // Primary warm-up count.
    int ph   = 0;  // Tick divider phase.
    // The primary warms up again after each stop.
    always @(posedge aclk) begin
        if (!aresetn) warm <= 20;
        else if (!clk_out.primary_osc_en) warm <= 0;
        else if (warm < 20) warm <= warm + 1;
        ph <= ph + 1;
    end
    // No secondary edges; the fast internal never settles.
    assign osc_in = {warm == 20, warm == 20 && ph % 4 == 0, 1'h0, 1'h0, 1'h0, ph % 3 == 1};
endmodule : pmc_osc_model
`default_nettype wire

// >>> dv/pmc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module pmc_top_bench;
    import pmc_pkg::*;
    localparam pmc_clk_out_t C_PRI  = '{1'h1, 1'h1, PMC_SRC_PRI, 1'h1};
    localparam pmc_clk_out_t C_INT  = '{1'h1, 1'h1, PMC_SRC_INT, 1'h0};
    localparam pmc_clk_out_t C_IDLE = '{1'h0, 1'h1, PMC_SRC_INT, 1'h0};
    localparam pmc_clk_out_t C_OFF  = '{1'h0, 1'h0, PMC_SRC_NONE, 1'h0};
    logic         aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0;
    logic         bready = 1'h0, arv = 1'h0, rready = 1'h0;
    logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]  wdata = 32'h0000_0000, rdata;
    logic [2:0]   ev = 3'h0; // Entry, wake, watchdog.
    logic         awr, wrr, bv, arr, rv, wdt_rst;
    logic [1:0]   bresp, rresp;
    pmc_osc_in_t  osc;
    pmc_clk_out_t co;
    int           err_count = 0, num_checks = 0, cyc = 0, tk = 0;
    pmc_top u_pmc_top (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wrr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready), .mode_entry(ev[0]),
        .irq_wake(ev[1]), .wdt_expire(ev[2]), .osc_in(osc), .clk_out(co), .wdt_reset(wdt_rst));
    pmc_osc_model u_pmc_osc_model (.aclk, .aresetn, .clk_out(co), .osc_in(osc));
    always #5 aclk = ~aclk;
    // Counts paused internal edges; a hang counts as a mismatch.
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (ev[0]) tk <= 0;
        else if (!co.periph_clk_en && osc.int_tick) tk <= tk + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            summarize();
        end
    end
    task cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp
    task wait_clk(input pmc_clk_out_t exp);
        int n;
        n = 0;
        while (co !== exp && n < 3000) begin
            @(negedge aclk);
            n++;
        end
        cmp({27'h0, co}, {27'h0, exp}, "clk_out");
    endtask : wait_clk
    task pulse(input int k);
        @(posedge aclk);
        ev[k] <= 1'h1;
        @(posedge aclk);
        ev <= 3'h0;
        @(negedge aclk);
    endtask : pulse
    // Ready is seen at the falling edge, settled for the next rise.
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        logic [1:0] r;
        ta = 0;
        tw = 0;
        @(posedge aclk);
        {awaddr, wdata, awv, wv, bready} <= {a, d, 3'h7};
        while (!(ta && tw)) begin
            @(negedge aclk);
            ta |= awr;
            tw |= wrr;
            @(posedge aclk);
            if (ta) awv <= 1'h0;
            if (tw) wv <= 1'h0;
        end
        do begin @(negedge aclk); ta = bv; r = bresp; @(posedge aclk); end while (!ta);
        bready <= 1'h0;
        cmp({30'h0, r}, 32'h0, "bresp");
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic t;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        {araddr, arv, rready} <= {a, 2'h3};
        do begin @(negedge aclk); t = arr; @(posedge aclk); end while (!t);
        arv <= 1'h0;
        do begin @(negedge aclk); t = rv; d = rdata; r = rresp; @(posedge aclk); end while (!t);
        rready <= 1'h0;
        cmp(d, exp, "rdata");
        cmp({30'h0, r}, {30'h0, er}, "rresp");
    endtask : rd
    task t_switch;
        rd(8'h00, 32'h0000_0008, 2'h0);
        wr(8'h00, 32'h0000_0002);
        cmp({27'h0, co}, {27'h0, C_PRI}, "select write");
        pulse(0);
        cmp({31'h0, co.periph_clk_en}, 32'h0, "paused");
        wait_clk(C_INT);
        cmp(32'(tk), 32'h0000_0008, "edges counted");
        rd(8'h00, 32'h0000_0002, 2'h0);
        $display("switch test done");
    endtask : t_switch
    task t_wdt;
        pulse(2);
        cmp({31'h0, wdt_rst}, 32'h1, "watchdog reset");
        cmp({27'h0, co}, {27'h0, C_INT}, "mode kept");
        $display("watchdog test done");
    endtask : t_wdt
    task t_idle;
        wr(8'h00, 32'h0000_0082);
        pulse(0);
        wait_clk(C_IDLE);
        pulse(1);
        repeat (500) @(negedge aclk);
        cmp({31'h0, co.cpu_clk_en}, 32'h0, "cpu held");
        wait_clk(C_PRI);
        rd(8'h00, 32'h0000_008A, 2'h0);
        $display("idle test done");
    endtask : t_idle
    task t_refuse;
        wr(8'h00, 32'h0000_0001);
        pulse(0);
        repeat (20) @(negedge aclk);
        cmp({27'h0, co}, {27'h0, C_PRI}, "entry ignored");
        rd(8'h10, 32'h0000_0000, 2'h2);
        $display("refuse test done");
    endtask : t_refuse
    task t_sleep;
        wr(8'h00, 32'h0000_0000);
        pulse(0);
        cmp({27'h0, co}, {27'h0, C_OFF}, "sleep clocks");
        rd(8'h00, 32'h0000_0000, 2'h0);
        pulse(1);
        wait_clk(C_PRI);
        rd(8'h00, 32'h0000_0008, 2'h0);
        $display("sleep test done");
    endtask : t_sleep
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        t_switch();
        t_wdt();
        t_idle();
        t_refuse();
        t_sleep();
        summarize();
    end
endmodule : pmc_top_bench
bind pmc_top pmc_top_asserts u_pmc_top_asserts (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq_wake, .wdt_expire,
    .clk_out, .wdt_reset);
`default_nettype wire
